// ==== design/rsp_defines.svh ====
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

// Register offsets
`define RSP_ADDR_XTAL_CFG 8'h00
`define RSP_ADDR_BOOST 8'h05
`define RSP_ADDR_PWR 8'h06
`define RSP_ADDR_TUNE_CAP 8'h07
`define RSP_ADDR_SYNTH_DIV 8'h08
`define RSP_ADDR_WORD_HI 8'h0b
`define RSP_ADDR_WORD_MID 8'h0c
`define RSP_ADDR_WORD_LO 8'h0d
`define RSP_ADDR_STATUS 8'h0e

// Field positions
`define RSP_XDIV_MSB 5
`define RSP_XDIV_LSB 4
`define RSP_BOOST_BIT 0
`define RSP_PWR_MSB 2
`define RSP_CAP_MSB 4
`define RSP_LO_DIVIDER_SELECT_MSB 5
`define RSP_LO_DIVIDER_SELECT_LSB 4
`define RSP_FRAC_BIT 0

// Reset values
`define RSP_RST_XTAL_CFG 8'h10
`define RSP_RST_BOOST 8'h00
`define RSP_RST_PWR 8'h07
`define RSP_RST_TUNE_CAP 8'h00
`define RSP_RST_SYNTH_DIV 8'h01
`define RSP_RST_WORD 8'h00

// Crystal divide ratios, synthesizer ratio limits and driver count
`define RSP_DIV_CODE0 3'h4
`define RSP_DIV_CODE1 3'h5
`define RSP_DIV_CODE2 3'h6
`define RSP_N_MIN 8'h0b
`define RSP_N_MAX 8'h48
`define RSP_DRIVERS 8

`endif

// ==== design/rsp_div.sv ====
`timescale 1ns/1ps
`include "rsp_defines.svh"
module rsp_div
  import rsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  rsp_div_if.div d
);
  logic [2:0] ratio;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic wrap;
  logic clk_out_reg;
  logic seen_reg;

  ////////////////////////////////////////////////////////////////
  // Ratio decode; the unused code falls back to the slowest rate
  assign ratio = (d.sel == RSP_XDIV_4) ? `RSP_DIV_CODE0 :
                 (d.sel == RSP_XDIV_5) ? `RSP_DIV_CODE1 :
                 `RSP_DIV_CODE2;
  assign wrap = d.run && (cnt_reg >= ratio - 3'h1);
  assign cnt_next = wrap ? 3'h0 : cnt_reg + 3'h1;
  assign d.tick = wrap;
  assign d.clk_out = clk_out_reg;
  assign d.first_edge = wrap && !seen_reg;

  ////////////////////////////////////////////////////////////////
  // Counter held at zero while the oscillator is off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 3'h0;
    end else if (!d.run) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Output high for the first ceil(ratio/2) cycles of each period, rising on wrap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_out_reg <= 1'b0;
    end else begin
      // Widened by a bit so the doubled count cannot wrap to a small value
      clk_out_reg <= d.run && (({1'b0, cnt_next} << 1) < {1'b0, ratio});
    end
  end

  // Remembers the first rising edge since the oscillator started
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen_reg <= 1'b0;
    end else if (!d.run) begin
      seen_reg <= 1'b0;
    end else if (wrap) begin
      seen_reg <= 1'b1;
    end
  end
endmodule

// ==== design/rsp_div_if.sv ====
`timescale 1ns/1ps
interface rsp_div_if;
  import rsp_pkg::*;
  rsp_xdiv_t sel;
  logic run;
  logic tick;
  logic clk_out;
  logic first_edge;
  modport ctrl (output sel, output run, input tick, input clk_out,
    input first_edge);
  modport div (input sel, input run, output tick, output clk_out,
    output first_edge);
endinterface

// ==== design/rsp_pkg.sv ====
package rsp_pkg;
  typedef enum logic [1:0] {
    RSP_XDIV_4 = 2'b00,
    RSP_XDIV_5 = 2'b01,
    RSP_XDIV_6 = 2'b10,
    RSP_XDIV_BAD = 2'b11
  } rsp_xdiv_t;

  typedef enum logic [1:0] {
    RSP_LO_LOW_CURRENT = 2'b00,
    RSP_LO_LPN_860 = 2'b01,
    RSP_LO_LPN_425 = 2'b10,
    RSP_LO_LPN_286 = 2'b11
  } rsp_lo_mode_t;
endpackage

// ==== design/rsp_top.sv ====
`timescale 1ns/1ps
`include "rsp_defines.svh"
// What this block does
// - Boost bit at 0x05 switches amplifier drive from 25% to 50% duty.
// - Five-bit field at 0x07 bits 4:0 selects output shunt capacitance.
// - Three-bit power level sets how many parallel drivers are active.
// - Divider yields a 3.2MHz time base; software picks the matching code.
// - Divider select codes 00, 01, 10 divide the crystal by 4, 5, 6.
// - Chip select low wakes the oscillator; first divider edge marks it.
// - Sixteen-bit fractional synthesizer with divide ratio from 11 to 72.
// - Carrier word spans 0x0b, 0x0c, 0x0d; software computes it.
// - LO divider select at 0x08 picks low-current or low-noise range.
// - Fractional enable cleared makes the synthesizer integer-N.
// - Fractional settings allow deviations from 1kHz to 100kHz.
module rsp_top
  import rsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_low_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic osc_enable,
  output logic time_base_tick,
  output logic time_base_clk,
  output logic drive_duty_boost,
  output logic [4:0] output_tuning_cap,
  output logic [7:0] driver_enable,
  output logic [7:0] synth_int_part,
  output logic [15:0] synth_frac_part,
  output logic fractional_mode_enable,
  output logic synth_ratio_valid,
  output rsp_lo_mode_t lo_divider_select,
  output logic [1:0] charge_pump_value,
  output logic [1:0] charge_pump_linearity
);
  logic [7:0] xtal_cfg_reg;
  logic [7:0] boost_reg;
  logic [7:0] pwr_reg;
  logic [7:0] cap_reg;
  logic [7:0] synth_div_reg;
  logic [7:0] word_hi_reg;
  logic [7:0] word_mid_reg;
  logic [7:0] word_lo_reg;
  logic [7:0] rd_next;
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic osc_on_reg;
  logic osc_ready_reg;
  logic [23:0] carrier_frequency_word;
  logic [2:0] driver_power_level;
  logic sel_xtal;
  logic sel_boost;
  logic sel_pwr;
  logic sel_cap;
  logic sel_sdiv;
  logic sel_hi;
  logic sel_mid;
  logic sel_lo;
  logic sel_stat;

  rsp_div_if div_bus ();

  ////////////////////////////////////////////////////////////////
  // Address decode
  assign sel_xtal = reg_addr == `RSP_ADDR_XTAL_CFG;
  assign sel_boost = reg_addr == `RSP_ADDR_BOOST;
  assign sel_pwr = reg_addr == `RSP_ADDR_PWR;
  assign sel_cap = reg_addr == `RSP_ADDR_TUNE_CAP;
  assign sel_sdiv = reg_addr == `RSP_ADDR_SYNTH_DIV;
  assign sel_hi = reg_addr == `RSP_ADDR_WORD_HI;
  assign sel_mid = reg_addr == `RSP_ADDR_WORD_MID;
  assign sel_lo = reg_addr == `RSP_ADDR_WORD_LO;
  assign sel_stat = reg_addr == `RSP_ADDR_STATUS;

  ////////////////////////////////////////////////////////////////
  // Configuration registers; only a write changes them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xtal_cfg_reg <= `RSP_RST_XTAL_CFG;
      boost_reg <= `RSP_RST_BOOST;
      pwr_reg <= `RSP_RST_PWR;
      cap_reg <= `RSP_RST_TUNE_CAP;
      synth_div_reg <= `RSP_RST_SYNTH_DIV;
    end else if (reg_wr_en) begin
      if (sel_xtal) xtal_cfg_reg <= reg_wr_data;
      if (sel_boost) boost_reg <= reg_wr_data;
      if (sel_pwr) pwr_reg <= reg_wr_data;
      if (sel_cap) cap_reg <= reg_wr_data;
      if (sel_sdiv) synth_div_reg <= reg_wr_data;
    end
  end

  // Carrier word bytes, kept apart so a byte write leaves the rest
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_hi_reg <= `RSP_RST_WORD;
      word_mid_reg <= `RSP_RST_WORD;
      word_lo_reg <= `RSP_RST_WORD;
    end else if (reg_wr_en) begin
      if (sel_hi) word_hi_reg <= reg_wr_data;
      if (sel_mid) word_mid_reg <= reg_wr_data;
      if (sel_lo) word_lo_reg <= reg_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux; status shows oscillator state, unmapped reads zero
  assign rd_next = sel_xtal ? xtal_cfg_reg :
                   sel_boost ? boost_reg :
                   sel_pwr ? pwr_reg :
                   sel_cap ? cap_reg :
                   sel_sdiv ? synth_div_reg :
                   sel_hi ? word_hi_reg :
                   sel_mid ? word_mid_reg :
                   sel_lo ? word_lo_reg :
                   sel_stat ? {6'h00, osc_ready_reg, osc_on_reg} :
                   8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rd_data <= 8'h00;
    end else begin
      reg_rd_data <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Chip select is a pin: two flops before any logic sees it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= chip_select_low_n;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  // Oscillator stays on once woken; only reset turns it off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_on_reg <= 1'b0;
      osc_ready_reg <= 1'b0;
    end else begin
      if (!cs_sync_reg) osc_on_reg <= 1'b1;
      if (div_bus.first_edge) osc_ready_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Crystal divider
  assign div_bus.sel =
    rsp_xdiv_t'(xtal_cfg_reg[`RSP_XDIV_MSB:`RSP_XDIV_LSB]);
  assign div_bus.run = osc_on_reg;

  rsp_div u_div (
    .clk(clk),
    .reset(reset),
    .d(div_bus)
  );

  assign osc_enable = osc_on_reg;
  assign time_base_tick = div_bus.tick;
  assign time_base_clk = div_bus.clk_out;

  ////////////////////////////////////////////////////////////////
  // Amplifier controls straight from held register bits
  assign drive_duty_boost = boost_reg[`RSP_BOOST_BIT];
  assign output_tuning_cap = cap_reg[`RSP_CAP_MSB:0];
  assign driver_power_level = pwr_reg[`RSP_PWR_MSB:0];

  // One enable per driver: level code k turns on drivers 0..k
  genvar gi;
  generate
    for (gi = 0; gi < `RSP_DRIVERS; gi++) begin : g_drv
      assign driver_enable[gi] = driver_power_level >= 3'(gi);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Synthesizer controls
  assign carrier_frequency_word = {word_hi_reg, word_mid_reg, word_lo_reg};
  assign fractional_mode_enable = synth_div_reg[`RSP_FRAC_BIT];
  assign synth_int_part = carrier_frequency_word[23:16];
  // Integer mode masks the fraction so the modulator sees zero
  assign synth_frac_part = fractional_mode_enable ?
    carrier_frequency_word[15:0] : 16'h0000;
  assign synth_ratio_valid = (synth_int_part >= `RSP_N_MIN) &&
    (synth_int_part <= `RSP_N_MAX);
  assign lo_divider_select =
    rsp_lo_mode_t'(synth_div_reg[`RSP_LO_DIVIDER_SELECT_MSB:`RSP_LO_DIVIDER_SELECT_LSB]);
  // Charge pump fields pass through; defaults come from reset
  assign charge_pump_value = synth_div_reg[7:6];
  assign charge_pump_linearity = synth_div_reg[3:2];
endmodule

// ==== verif/rf_synth_pa_config_test.sv ====
`timescale 1ns/1ps
`include "rsp_defines.svh"
module rf_synth_pa_config_test;
  import rsp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic chip_select_low_n = 1'b1;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data, driver_enable, synth_int_part;
  logic osc_enable, time_base_tick, time_base_clk, drive_duty_boost;
  logic fractional_mode_enable, synth_ratio_valid;
  logic [4:0] output_tuning_cap;
  logic [15:0] synth_frac_part;
  rsp_lo_mode_t lo_divider_select;
  logic [1:0] charge_pump_value, charge_pump_linearity;
  logic [6:0] duty_pct;
  logic [12:0] cap_ff;
  logic [3:0] active_drivers;
  integer seed = 32, miscompares = 0, comparisons = 0, cycles = 0, i, n, h;
  logic [7:0] v, rv, cap, hi, ctl;
  logic bst;
  logic [7:0] ra [7] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h3f};
  logic [7:0] rz [7] = '{8'h10, 8'h00, 8'h07, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] lim [4] = '{8'h0a, 8'h0b, 8'h48, 8'h49};
  rsp_top DUT (
    .clk(clk), .reset(reset), .chip_select_low_n(chip_select_low_n),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .osc_enable(osc_enable),
    .time_base_tick(time_base_tick), .time_base_clk(time_base_clk),
    .drive_duty_boost(drive_duty_boost),
    .output_tuning_cap(output_tuning_cap), .driver_enable(driver_enable),
    .synth_int_part(synth_int_part), .synth_frac_part(synth_frac_part),
    .fractional_mode_enable(fractional_mode_enable),
    .synth_ratio_valid(synth_ratio_valid),
    .lo_divider_select(lo_divider_select),
    .charge_pump_value(charge_pump_value),
    .charge_pump_linearity(charge_pump_linearity)
  );
  rsp_analog_model u_far (
    .drive_duty_boost(drive_duty_boost),
    .output_tuning_cap(output_tuning_cap), .driver_enable(driver_enable),
    .duty_pct(duty_pct), .cap_ff(cap_ff), .active_drivers(active_drivers)
  );
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobe lowered at the taking edge, outputs sampled mid-cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    rv = reg_rd_data;
  endtask
  // Cycles from one tick to the next, bounded in case ticks stop
  task automatic period;
    for (n = 0; n < 50 && time_base_tick !== 1'b1; n++) @(negedge clk);
    h = 0;
    for (n = 1; n < 50; n++) begin
      @(negedge clk);
      h = h + time_base_clk;
      if (time_base_tick === 1'b1) break;
    end
  endtask
  task summarize;
    $display("Counts: %0d comparisons, %0d miscompares", comparisons,
      miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // Reset contents, unmapped place reads zero
    for (i = 0; i < 7; i++) begin
      rd(ra[i]);
      check(rv, rz[i]);
    end
    check(osc_enable, 1'b0);
    @(posedge clk);
    chip_select_low_n <= 1'b0;
    for (n = 0; n < 20 && osc_enable !== 1'b1; n++) @(negedge clk);
    check(osc_enable, 1'b1);
    // Divider codes 00, 01, 10; first period may be cut by the change
    for (i = 0; i < 3; i++) begin
      wr(8'h00, {2'b00, i[1:0], 4'h0});
      period;
      period;
      check(n, 4 + i);
      check(h, (5 + i) / 2);
    end
    // Status shows the oscillator on and its first divider edge seen
    rd(8'h0e);
    check(rv, 8'h03);
    // Ratio corners first, then random settings
    for (i = 0; i < 40; i++) begin
      hi = (i < 4) ? lim[i] : 8'h0a + 8'($random(seed) & 63);
      cap = (i == 4) ? 8'h1e : 8'($unsigned($random(seed)) % 31);
      ctl = 8'($random(seed)) & 8'h31;
      v = 8'($random(seed));
      bst = v[0] & (hi > 8'h35);
      wr(8'h0b, hi);
      wr(8'h0c, v);
      wr(8'h0d, v | 8'h01);
      wr(8'h05, {7'h00, bst});
      wr(8'h07, cap);
      wr(8'h06, {5'h00, v[3:1]});
      wr(8'h08, ctl);
      wr(8'h3f, 8'hff);
      check(synth_int_part, hi);
      check(synth_ratio_valid, hi >= `RSP_N_MIN && hi <= `RSP_N_MAX);
      check(synth_frac_part, ctl[0] ? {v, v | 8'h01} : 16'h0000);
      check(lo_divider_select, ctl[5:4]);
      check(duty_pct, bst ? 7'h32 : 7'h19);
      check(cap_ff, 13'(cap) * 13'h00b4);
      check(driver_enable, 8'hff >> (3'h7 - v[3:1]));
      check(active_drivers, {1'b0, v[3:1]} + 4'h1);
      check({charge_pump_value, charge_pump_linearity}, 4'h0);
      rd(8'h07);
      check(rv, cap);
      rd(8'h3f);
      check(rv, 8'h00);
    end
    summarize;
  end
endmodule

// ==== verif/rsp_analog_model.sv ====
`timescale 1ns/1ps
module rsp_analog_model (
  input wire logic drive_duty_boost,
  input wire logic [4:0] output_tuning_cap,
  input wire logic [7:0] driver_enable,
  output logic [6:0] duty_pct,
  output logic [12:0] cap_ff,
  output logic [3:0] active_drivers
);
  // Final stage duty, shunt capacitance in fF, live driver count
  assign duty_pct = drive_duty_boost ? 7'h32 : 7'h19;
  assign cap_ff = 13'(output_tuning_cap) * 13'h00b4;
  assign active_drivers = 4'($countones(driver_enable));
endmodule

// ==== verif/rsp_top_monitor.sv ====
`timescale 1ns/1ps
module rsp_top_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_low_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic osc_enable,
  input wire logic time_base_tick,
  input wire logic drive_duty_boost,
  input wire logic [4:0] output_tuning_cap,
  input wire logic [7:0] driver_enable,
  input wire logic [7:0] synth_int_part,
  input wire logic [15:0] synth_frac_part,
  input wire logic fractional_mode_enable
);
  logic [3:0] gap_reg;
  logic [3:0] quiet_reg;
  logic [1:0] code_reg;
  logic seen_reg;
  wire wr_div = reg_wr_en && reg_addr == 8'h00;
  wire [3:0] ratio = (code_reg == 2'b00) ? 4'h4 :
    (code_reg == 2'b01) ? 4'h5 : 4'h6;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // Tick spacing; quiet count skips periods cut short by a code change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_reg <= 4'h0;
      quiet_reg <= 4'h0;
      code_reg <= 2'b01;
      seen_reg <= 1'b0;
    end else begin
      gap_reg <= time_base_tick ? 4'h1 : gap_reg + 4'(gap_reg != 4'hf);
      quiet_reg <= wr_div ? 4'h0 : quiet_reg + 4'(quiet_reg != 4'hf);
      code_reg <= wr_div ? reg_wr_data[5:4] : code_reg;
      seen_reg <= seen_reg | time_base_tick;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Pin low long enough for the synchronizer, then oscillator stays on
  sequence pin_held_s;
    !chip_select_low_n [*5];
  endsequence
  chk_osc_wakes_on: assert property (
    pin_held_s |-> osc_enable ##1 osc_enable)
    else $error("oscillator not on after chip select low");
  chk_tick_spacing: assert property (
    time_base_tick && seen_reg && quiet_reg > 4'h8 |-> gap_reg == ratio)
    else $error("time base period does not match divider code");
  chk_boost_follows: assert property (
    reg_wr_en && reg_addr == 8'h05
    |=> drive_duty_boost == $past(reg_wr_data[0]))
    else $error("boost output does not follow write");
  chk_cap_follows: assert property (
    reg_wr_en && reg_addr == 8'h07
    |=> output_tuning_cap == $past(reg_wr_data[4:0]))
    else $error("tuning cap output does not follow write");
  chk_driver_count: assert property (
    reg_wr_en && reg_addr == 8'h06
    |=> driver_enable == 8'hff >> (3'h7 - $past(reg_wr_data[2:0])))
    else $error("driver enables do not match power level");
  chk_word_high: assert property (
    reg_wr_en && reg_addr == 8'h0b
    |=> synth_int_part == $past(reg_wr_data))
    else $error("integer part does not follow write");
  chk_integer_mode: assert property (
    !fractional_mode_enable |-> synth_frac_part == 16'h0000)
    else $error("fraction passed in integer mode");
  chk_fields_hold: assert property (
    !reg_wr_en |=> $stable(driver_enable)
    && $stable(output_tuning_cap) && $stable(synth_int_part))
    else $error("field changed without a write");
endmodule

bind rsp_top rsp_top_monitor u_mon (.clk(clk), .reset(reset),
  .chip_select_low_n(chip_select_low_n), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .osc_enable(osc_enable), .time_base_tick(time_base_tick),
  .drive_duty_boost(drive_duty_boost),
  .output_tuning_cap(output_tuning_cap), .driver_enable(driver_enable),
  .synth_int_part(synth_int_part), .synth_frac_part(synth_frac_part),
  .fractional_mode_enable(fractional_mode_enable));
